// ---- design/spt_pkg.sv ----
`default_nettype none
package spt_pkg;

  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam int CLK_PERIOD_NS   = 50;
  localparam int TURN_ON_NS      = 100;
  localparam int TURN_ON_CYC_RAW = (TURN_ON_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int TURN_ON_CYC     = (TURN_ON_CYC_RAW < 1) ? 1 : TURN_ON_CYC_RAW;

  // ----------------------------------------
  // Field encodings
  // ----------------------------------------
  localparam logic [1:0] DLY_0       = 2'h0;
  localparam logic [1:0] DLY_1       = 2'h1;
  localparam logic [1:0] DLY_2       = 2'h2;
  localparam logic [1:0] IRQ_READY   = 2'h0;
  localparam logic [1:0] IRQ_BLOCK   = 2'h1;
  localparam logic [1:0] IRQ_FSYNC   = 2'h2;
  localparam logic [1:0] IRQ_SYNCERR = 2'h3;
  localparam logic [1:0] CMP_MSB     = 2'h0;
  localparam logic [1:0] CMP_LSB8    = 2'h1;
  localparam logic [1:0] CMP_MULAW   = 2'h2;
  localparam logic [1:0] CMP_ALAW    = 2'h3;

  // ----------------------------------------
  // Companding
  // ----------------------------------------
  localparam int          COMPAND_BITS = 8;
  localparam logic [7:0]  ALAW_XOR     = 8'h55;
  localparam logic [12:0] MULAW_CLIP   = 13'h1FDE;
  localparam logic [13:0] MULAW_BIAS   = 14'h0021;

  typedef enum logic [1:0] {
    TX_IDLE  = 2'b00,
    TX_DELAY = 2'b01,
    TX_SHIFT = 2'b10
  } spt_tx_state_t;

endpackage
`default_nettype wire

// ---- design/spt_sync.sv ----
`timescale 1ns/1ns
`default_nettype none
module spt_sync #(
  parameter int W = 1
) (
  input  wire logic         core_clk_i,
  input  wire logic         nrst_i,
  input  wire logic [W-1:0] async_i,
  output logic      [W-1:0] sync_o
);

  // ----------------------------------------
  // Two-stage synchroniser
  // ----------------------------------------
  logic [W-1:0] meta;

  always_ff @(posedge core_clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      meta   <= '0;
      sync_o <= '0;
    end
    else
    begin
      meta   <= async_i;
      sync_o <= meta;
    end
  end

endmodule
`default_nettype wire

// ---- design/spt_tx_framing.sv ----
// What this block does
// - Delay first transmit bit by 0-2 clocks.
// - Frame starts where sync first seen active.
// - Zero delay: first bit out on sync.
// - Zero delay receive samples at first fall.
// - Two-bit delay skips the framing bit and one more.
// - Turn-on delay on first bit, A-bis any.
// - Mode 00 interrupts on ready rising.
// - Mode 01 interrupts at word end, multichannel only.
// - Mode 10 interrupts per sync, even when disabled.
// - Mode 11 interrupts when sync error sets.
// - Direction 0: sync pin is input, polarity-conditioned.
// - Both bits 1: generator sync drives pin.
// - Direction 1, select 0: copy makes pulse.
// - Input syncs sampled on internal clock falls, except zero-delay transmit start.
// - Output syncs and data change on rises.
// - Internal syncs active high, polarity inverts pins.
// - Transmit clock polarity inverts pin both ways.
// - Receive clock polarity inverts pin both ways.
// - Generator sync bit aligns to receive sync pin.
// - Compand 11 sends A-law 8-bit MSB first.
// - Compand 00 plain, 01 LSB first, 10 mu-law.
// - Unexpected sync aborts, flags, resends word.
`timescale 1ns/1ns
`default_nettype none
module spt_tx_framing #(
  parameter int WORD_W = 16,
  parameter int RX_W   = 8
) (
  input  wire logic              core_clk_i,
  input  wire logic              nrst_i,
  input  wire logic              tx_enable_i,
  input  wire logic [WORD_W-1:0] tx_data_i,
  input  wire logic              tx_data_valid_i,
  output logic                   tx_ready_flag_o,
  input  wire logic [1:0]        tx_data_delay_i,
  input  wire logic [1:0]        rx_data_delay_i,
  input  wire logic              data_pin_delay_enable_i,
  input  wire logic              abis_mode_i,
  input  wire logic              abis_bit_enable_i,
  input  wire logic [1:0]        tx_irq_mode_i,
  input  wire logic              multichannel_active_i,
  output logic                   tx_irq_o,
  output logic                   tx_sync_error_o,
  input  wire logic              tx_sync_error_clear_i,
  input  wire logic              tx_unexpected_sync_ignore_i,
  input  wire logic [1:0]        tx_compand_mode_i,
  input  wire logic              tx_framesync_dir_i,
  input  wire logic              tx_framesync_gen_select_i,
  input  wire logic              tx_framesync_polarity_i,
  input  wire logic              rx_framesync_polarity_i,
  input  wire logic              tx_clock_polarity_i,
  input  wire logic              rx_clock_polarity_i,
  input  wire logic              tx_clock_dir_i,
  input  wire logic              rx_clock_dir_i,
  input  wire logic              generator_sync_to_input_i,
  input  wire logic              generator_clock_i,
  input  wire logic              generator_frame_sync_i,
  output logic                   generator_resync_o,
  output logic                   tx_data_pin_o,
  output logic                   tx_data_pin_oe_o,
  input  wire logic              rx_data_pin_i,
  input  wire logic              tx_framesync_pin_i,
  output logic                   tx_framesync_pin_o,
  output logic                   tx_framesync_pin_oe_o,
  input  wire logic              rx_framesync_pin_i,
  input  wire logic              tx_clock_pin_i,
  output logic                   tx_clock_pin_o,
  output logic                   tx_clock_pin_oe_o,
  input  wire logic              rx_clock_pin_i,
  output logic                   rx_clock_pin_o,
  output logic                   rx_clock_pin_oe_o,
  output logic [RX_W-1:0]        rx_word_o,
  output logic                   rx_word_valid_o
);

  localparam logic [7:0] TON = 8'(spt_pkg::TURN_ON_CYC);
  localparam logic [5:0] TX_BITS = 6'(WORD_W);
  localparam logic [5:0] CMP_BITS = 6'(spt_pkg::COMPAND_BITS);
  localparam logic [5:0] RX_BITS = 6'(RX_W);

  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!nrst_i);

  // ----------------------------------------
  // Companding
  // ----------------------------------------
  function automatic logic [7:0] spt_alaw(input logic [15:0] d);
    logic [11:0] mag;
    logic [2:0]  seg;
    logic [3:0]  mant;
    mag = d[15] ? ~d[14:3] : d[14:3];
    seg = 3'h0;
    for (int i = 1; i < 8; i++)
      if (mag[i+4])
        seg = 3'(i);
    mant = (seg == 3'h0) ? mag[4:1] : 4'(mag >> seg);
    return {~d[15], seg, mant} ^ spt_pkg::ALAW_XOR;
  endfunction

  function automatic logic [7:0] spt_mulaw(input logic [15:0] d);
    logic [12:0] mag;
    logic [13:0] big;
    logic [2:0]  seg;
    logic [3:0]  mant;
    mag = d[15] ? ~d[14:2] : d[14:2];
    if (mag > spt_pkg::MULAW_CLIP)
      mag = spt_pkg::MULAW_CLIP;
    big = {1'b0, mag} + spt_pkg::MULAW_BIAS;
    seg = 3'h0;
    for (int i = 0; i < 8; i++)
      if (big[i+5])
        seg = 3'(i);
    mant = 4'(big >> (4'(seg) + 4'h1));
    return ~{d[15], seg, mant};
  endfunction

  // ----------------------------------------
  // Pin synchronisers and internal clocks
  // ----------------------------------------
  logic [4:0] pin_s;
  logic       s_txc, s_rxc, s_txfs, s_rxfs, s_rxd;

  spt_sync #(.W(5)) u_sync (
    .core_clk_i (core_clk_i),
    .nrst_i     (nrst_i),
    .async_i    ({tx_clock_pin_i, rx_clock_pin_i, tx_framesync_pin_i, rx_framesync_pin_i, rx_data_pin_i}),
    .sync_o     (pin_s)
  );
  assign {s_txc, s_rxc, s_txfs, s_rxfs, s_rxd} = pin_s;

  logic int_txc, int_rxc, txc_q, rxc_q, tx_rise, tx_fall, rx_fall;
  assign int_txc = tx_clock_dir_i ? generator_clock_i : (s_txc ^ tx_clock_polarity_i);
  assign int_rxc = rx_clock_dir_i ? generator_clock_i : (s_rxc ^ rx_clock_polarity_i);
  assign tx_rise = int_txc & ~txc_q;
  assign tx_fall = ~int_txc & txc_q;
  assign rx_fall = ~int_rxc & rxc_q;

  always_ff @(posedge core_clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      txc_q             <= 1'b0;
      rxc_q             <= 1'b0;
      tx_clock_pin_o    <= 1'b0;
      tx_clock_pin_oe_o <= 1'b0;
      rx_clock_pin_o    <= 1'b0;
      rx_clock_pin_oe_o <= 1'b0;
    end
    else
    begin
      txc_q             <= int_txc;
      rxc_q             <= int_rxc;
      tx_clock_pin_o    <= generator_clock_i ^ tx_clock_polarity_i;
      tx_clock_pin_oe_o <= tx_clock_dir_i;
      rx_clock_pin_o    <= generator_clock_i ^ rx_clock_polarity_i;
      rx_clock_pin_oe_o <= rx_clock_dir_i;
    end
  end

  // ----------------------------------------
  // Transmit frame sync
  // ----------------------------------------
  spt_pkg::spt_tx_state_t state;
  logic gen_fs_q, copy_fs_q, copy_pend, copy_now, int_txfs, fs_lvl_q, fs_smp_q;
  logic fs_edge, frame_start;

  assign int_txfs = !tx_framesync_dir_i ? (s_txfs ^ tx_framesync_polarity_i) :
                    tx_framesync_gen_select_i ? gen_fs_q : copy_fs_q;
  assign fs_edge = int_txfs & ~fs_lvl_q;
  assign frame_start = (tx_data_delay_i == spt_pkg::DLY_0) ? fs_edge :
                       (tx_fall & int_txfs & ~fs_smp_q);

  always_ff @(posedge core_clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      gen_fs_q  <= 1'b0;
      copy_fs_q <= 1'b0;
      copy_pend <= 1'b0;
    end
    else
    begin
      if (tx_rise)
      begin
        gen_fs_q  <= generator_frame_sync_i;
        copy_fs_q <= copy_pend;
      end
      if (copy_now)
        copy_pend <= 1'b1;
      else if (tx_rise)
        copy_pend <= 1'b0;
    end
  end

  always_ff @(posedge core_clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      fs_lvl_q              <= 1'b0;
      fs_smp_q              <= 1'b0;
      tx_framesync_pin_o    <= 1'b0;
      tx_framesync_pin_oe_o <= 1'b0;
    end
    else
    begin
      fs_lvl_q <= int_txfs;
      if (tx_fall)
        fs_smp_q <= int_txfs;
      tx_framesync_pin_o    <= (tx_framesync_gen_select_i ? gen_fs_q : copy_fs_q) ^ tx_framesync_polarity_i;
      tx_framesync_pin_oe_o <= tx_framesync_dir_i;
    end
  end

  // ----------------------------------------
  // Data register and copy to shifter
  // ----------------------------------------
  logic [WORD_W-1:0] hold, word, sh;
  logic              hold_full, loaded;
  logic [5:0]        nbits, bit_cnt;
  logic [1:0]        dcnt;
  logic              word_done, unexpected, rdy_q;

  assign tx_ready_flag_o = ~hold_full;
  assign copy_now = tx_enable_i & hold_full & ~loaded & (state == spt_pkg::TX_IDLE);

  always_ff @(posedge core_clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      hold      <= '0;
      hold_full <= 1'b0;
    end
    else if (!tx_enable_i)
      hold_full <= 1'b0;
    else if (tx_data_valid_i && !hold_full)
    begin
      hold      <= tx_data_i;
      hold_full <= 1'b1;
    end
    else if (copy_now)
      hold_full <= 1'b0;
  end

  always_ff @(posedge core_clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      word  <= '0;
      nbits <= TX_BITS;
    end
    else if (copy_now)
    begin
      case (tx_compand_mode_i)
        spt_pkg::CMP_LSB8:  word <= {{<<{hold[7:0]}}, {(WORD_W-8){1'b0}}};
        spt_pkg::CMP_MULAW: word <= {spt_mulaw(16'(hold)), {(WORD_W-8){1'b0}}};
        spt_pkg::CMP_ALAW:  word <= {spt_alaw(16'(hold)), {(WORD_W-8){1'b0}}};
        default:            word <= hold;
      endcase
      nbits <= (tx_compand_mode_i == spt_pkg::CMP_MSB) ? TX_BITS : CMP_BITS;
    end
  end

  // ----------------------------------------
  // Transmit sequencer
  // ----------------------------------------
  assign word_done = (state == spt_pkg::TX_SHIFT) & tx_rise & (bit_cnt == 6'h0);
  assign unexpected = tx_enable_i & frame_start & (state != spt_pkg::TX_IDLE)
                      & ~tx_unexpected_sync_ignore_i;

  always_ff @(posedge core_clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      state   <= spt_pkg::TX_IDLE;
      sh      <= '0;
      loaded  <= 1'b0;
      bit_cnt <= 6'h0;
      dcnt    <= 2'h0;
    end
    else if (!tx_enable_i)
    begin
      state  <= spt_pkg::TX_IDLE;
      loaded <= 1'b0;
    end
    else if (copy_now)
    begin
      sh     <= (tx_compand_mode_i == spt_pkg::CMP_MSB) ? hold : sh;
      loaded <= 1'b1;
    end
    else if ((state == spt_pkg::TX_IDLE && frame_start && loaded) || unexpected)
    begin
      sh      <= word;
      bit_cnt <= nbits - 6'h1;
      dcnt    <= tx_data_delay_i;
      state   <= (tx_data_delay_i == spt_pkg::DLY_0) ? spt_pkg::TX_SHIFT : spt_pkg::TX_DELAY;
    end
    else
    begin
      if (state == spt_pkg::TX_IDLE && loaded)
        sh <= word;
      case (state)
        spt_pkg::TX_DELAY:
          if (tx_rise)
          begin
            if (dcnt <= spt_pkg::DLY_1)
              state <= spt_pkg::TX_SHIFT;
            else
              dcnt <= dcnt - 2'h1;
          end
        spt_pkg::TX_SHIFT:
          if (tx_rise)
          begin
            if (bit_cnt == 6'h0)
            begin
              state  <= spt_pkg::TX_IDLE;
              loaded <= 1'b0;
            end
            else
            begin
              sh      <= sh << 1;
              bit_cnt <= bit_cnt - 6'h1;
            end
          end
        default: state <= spt_pkg::TX_IDLE;
      endcase
    end
  end

  // ----------------------------------------
  // Data pin drive and turn-on delay
  // ----------------------------------------
  logic       drive_req, drive_q;
  logic [7:0] ton_cnt;

  assign drive_req = (state == spt_pkg::TX_SHIFT) & (~abis_mode_i | abis_bit_enable_i);

  always_ff @(posedge core_clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      drive_q          <= 1'b0;
      ton_cnt          <= 8'h00;
      tx_data_pin_o    <= 1'b0;
      tx_data_pin_oe_o <= 1'b0;
    end
    else
    begin
      drive_q       <= drive_req;
      tx_data_pin_o <= sh[WORD_W-1];
      if (!drive_req)
      begin
        tx_data_pin_oe_o <= 1'b0;
        ton_cnt          <= 8'h00;
      end
      else if (!drive_q && data_pin_delay_enable_i)
        ton_cnt <= TON;
      else if (ton_cnt != 8'h00)
        ton_cnt <= ton_cnt - 8'h01;
      else
        tx_data_pin_oe_o <= 1'b1;
    end
  end

  // ----------------------------------------
  // Sync error flag and interrupt
  // ----------------------------------------
  logic irq_evt;

  always_comb
  begin
    case (tx_irq_mode_i)
      spt_pkg::IRQ_READY: irq_evt = ~hold_full & ~rdy_q;
      spt_pkg::IRQ_BLOCK: irq_evt = multichannel_active_i & word_done;
      spt_pkg::IRQ_FSYNC: irq_evt = fs_edge;
      default:            irq_evt = unexpected;
    endcase
  end

  always_ff @(posedge core_clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      tx_sync_error_o <= 1'b0;
      rdy_q           <= 1'b1;
      tx_irq_o        <= 1'b0;
    end
    else
    begin
      if (unexpected)
        tx_sync_error_o <= 1'b1;
      else if (tx_sync_error_clear_i)
        tx_sync_error_o <= 1'b0;
      rdy_q    <= ~hold_full;
      tx_irq_o <= irq_evt;
    end
  end

  // ----------------------------------------
  // Receive framing
  // ----------------------------------------
  logic            int_rxfs, rfs_q, rfs_lvl_q, rstart;
  logic [1:0]      rskip;
  logic [5:0]      rbits;
  logic [RX_W-1:0] rsh;

  assign int_rxfs = s_rxfs ^ rx_framesync_polarity_i;
  assign rstart = int_rxfs & ~rfs_q;

  always_ff @(posedge core_clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      rfs_q           <= 1'b0;
      rskip           <= 2'h0;
      rbits           <= 6'h0;
      rsh             <= '0;
      rx_word_o       <= '0;
      rx_word_valid_o <= 1'b0;
    end
    else
    begin
      rx_word_valid_o <= 1'b0;
      if (rx_fall)
      begin
        rfs_q <= int_rxfs;
        if (rstart && rbits == 6'h0 && rx_data_delay_i == spt_pkg::DLY_0)
        begin
          rsh   <= {rsh[RX_W-2:0], s_rxd};
          rbits <= RX_BITS - 6'h1;
        end
        else if (rstart && rbits == 6'h0)
        begin
          rskip <= rx_data_delay_i - 2'h1;
          rbits <= RX_BITS;
        end
        else if (rbits != 6'h0 && rskip != 2'h0)
          rskip <= rskip - 2'h1;
        else if (rbits != 6'h0)
        begin
          rsh   <= {rsh[RX_W-2:0], s_rxd};
          rbits <= rbits - 6'h1;
          if (rbits == 6'h1)
          begin
            rx_word_o       <= {rsh[RX_W-2:0], s_rxd};
            rx_word_valid_o <= 1'b1;
          end
        end
      end
    end
  end

  always_ff @(posedge core_clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      rfs_lvl_q          <= 1'b0;
      generator_resync_o <= 1'b0;
    end
    else
    begin
      rfs_lvl_q          <= int_rxfs;
      generator_resync_o <= generator_sync_to_input_i & int_rxfs & ~rfs_lvl_q;
    end
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  irq_one_pulse_a: assert property (tx_irq_o |=> !tx_irq_o)
    else $error("interrupt longer than one cycle");
  irq_on_sync_a: assert property (tx_irq_mode_i == spt_pkg::IRQ_FSYNC && fs_edge |=> tx_irq_o)
    else $error("no interrupt on frame sync");
  irq_on_error_a: assert property (tx_irq_mode_i == spt_pkg::IRQ_SYNCERR && unexpected |=> tx_irq_o && tx_sync_error_o)
    else $error("no interrupt on sync error");
  irq_on_ready_a: assert property (tx_irq_mode_i == spt_pkg::IRQ_READY && $rose(tx_ready_flag_o) |=> tx_irq_o)
    else $error("no interrupt on ready");
  fs_input_dir_a: assert property (!tx_framesync_dir_i |=> !tx_framesync_pin_oe_o)
    else $error("frame sync pin driven while input");
  fs_gen_out_a: assert property (tx_framesync_dir_i && tx_framesync_gen_select_i
    |=> tx_framesync_pin_o == ($past(gen_fs_q) ^ $past(tx_framesync_polarity_i)))
    else $error("generator sync not on pin");
  zero_delay_start_a: assert property (state == spt_pkg::TX_IDLE && tx_enable_i && loaded && !copy_now
    && tx_data_delay_i == spt_pkg::DLY_0 && fs_edge |=> state == spt_pkg::TX_SHIFT)
    else $error("zero delay did not start");
  turn_on_hold_a: assert property (data_pin_delay_enable_i && drive_req && !drive_q |=> !tx_data_pin_oe_o [*2])
    else $error("data pin driven without turn-on delay");
  tx_clk_pol_a: assert property (tx_clock_dir_i
    |=> tx_clock_pin_o == ($past(generator_clock_i) ^ $past(tx_clock_polarity_i)))
    else $error("transmit clock polarity wrong");

endmodule
`default_nettype wire

// ---- test/spt_codec_model.sv ----
`timescale 1ns/1ns
`default_nettype none
module spt_codec_model (
  input  wire logic        start_i,
  input  wire logic        glitch_i,
  input  wire logic        clk_pol_i,
  input  wire logic        fs_pol_i,
  input  wire logic [19:0] rx_pat_i,
  input  wire logic        tx_data_i,
  input  wire logic        tx_oe_i,
  output logic             clk_pin_o,
  output logic             fs_pin_o,
  output logic             rx_pin_o,
  output logic      [31:0] cap_o,
  output logic             busy_o
);
  // ----------------------------------------
  // Idle levels: clock stands still outside frames
  // ----------------------------------------
  initial
  begin
    busy_o   = 1'b0;
    rx_pin_o = 1'b0;
    clk_pin_o = 1'b0;
    fs_pin_o  = 1'b0;
    cap_o    = 32'h00000000;
  end

  always @(clk_pol_i or fs_pol_i)
  begin
    if (busy_o !== 1'b1)
    begin
      clk_pin_o = clk_pol_i;
      fs_pin_o  = fs_pol_i;
    end
  end

  // ----------------------------------------
  // One frame of 26 bit periods
  // ----------------------------------------
  always @(posedge start_i)
  begin
    busy_o = 1'b1;
    cap_o  = 32'h00000000;
    for (int k = 0; k < 26; k++)
    begin
      clk_pin_o = ~clk_pol_i;
      fs_pin_o  = ((k == 0) || (glitch_i && (k == 8))) ^ fs_pol_i;
      rx_pin_o  = (k < 20) ? rx_pat_i[19-k] : ~rx_pin_o;
      #200;
      clk_pin_o = clk_pol_i;
      #190;
      cap_o = {cap_o[30:0], tx_oe_i & tx_data_i};
      #10;
    end
    fs_pin_o = fs_pol_i;
    rx_pin_o = ~rx_pin_o;
    busy_o   = 1'b0;
  end
endmodule
`default_nettype wire

// ---- test/spt_tx_framing_tb_top.sv ----
`timescale 1ns/1ns
`default_nettype none
module spt_tx_framing_tb_top;
  typedef struct packed {
    logic [1:0]  dly;
    logic        cpol;
    logic        fpol;
    logic        dpe;
    logic [15:0] word;
    logic [19:0] pat;
  } spt_row_t;
  localparam spt_row_t ROWS [4] = '{
    '{2'h0, 1'h0, 1'h0, 1'h0, 16'hA5C3, 20'hB3C5A},
    '{2'h1, 1'h1, 1'h0, 1'h1, 16'h8001, 20'h5A3C6},
    '{2'h2, 1'h0, 1'h1, 1'h1, 16'h7FFE, 20'hC69A5},
    '{2'h1, 1'h1, 1'h1, 1'h0, 16'h1234, 20'h3E1D2}
  };

  logic        core_clk_i, nrst_i, tx_enable_i, tx_data_valid_i, data_pin_delay_enable_i;
  logic        abis_mode_i, abis_bit_enable_i, multichannel_active_i, tx_sync_error_clear_i;
  logic        tx_unexpected_sync_ignore_i, tx_framesync_dir_i, tx_framesync_gen_select_i;
  logic        tx_framesync_polarity_i, rx_framesync_polarity_i, tx_clock_polarity_i, rx_clock_polarity_i;
  logic        tx_clock_dir_i, rx_clock_dir_i, generator_sync_to_input_i, generator_clock_i;
  logic        generator_frame_sync_i, start, glitch, gen_run, busy, resync;
  logic [1:0]  tx_data_delay_i, rx_data_delay_i, tx_irq_mode_i, tx_compand_mode_i, gcnt;
  logic [15:0] tx_data_i;
  logic        tx_ready_flag_o, tx_irq_o, tx_sync_error_o, tx_data_pin_o, tx_data_pin_oe_o;
  logic        tx_framesync_pin_o, tx_framesync_pin_oe_o, tx_clock_pin_o, tx_clock_pin_oe_o;
  logic        rx_clock_pin_o, rx_clock_pin_oe_o, rx_word_valid_o, m_clk, m_fs, m_rx;
  logic [7:0]  rx_word_o, rx_last;
  logic [19:0] pat;
  logic [31:0] cap;
  wire logic   rx_data_pin_i, tx_framesync_pin_i, rx_framesync_pin_i, tx_clock_pin_i, rx_clock_pin_i;
  int          error_cnt, compares, irq_cnt, irq_base, act_cnt, act_base, rs_cnt;

  // ----------------------------------------
  // Pin resolution, design and partner
  // ----------------------------------------
  assign tx_framesync_pin_i = tx_framesync_pin_oe_o ? tx_framesync_pin_o : m_fs;
  assign tx_clock_pin_i     = tx_clock_pin_oe_o ? tx_clock_pin_o : m_clk;
  assign rx_clock_pin_i     = rx_clock_pin_oe_o ? rx_clock_pin_o : m_clk;
  assign rx_framesync_pin_i = m_fs;
  assign rx_data_pin_i      = m_rx;

  spt_tx_framing #(
    .WORD_W (16),
    .RX_W   (8)
  ) u_dut (
    .core_clk_i, .nrst_i, .tx_enable_i, .tx_data_i, .tx_data_valid_i, .tx_ready_flag_o,
    .tx_data_delay_i, .rx_data_delay_i, .data_pin_delay_enable_i, .abis_mode_i, .abis_bit_enable_i,
    .tx_irq_mode_i, .multichannel_active_i, .tx_irq_o, .tx_sync_error_o, .tx_sync_error_clear_i,
    .tx_unexpected_sync_ignore_i, .tx_compand_mode_i, .tx_framesync_dir_i, .tx_framesync_gen_select_i,
    .tx_framesync_polarity_i, .rx_framesync_polarity_i, .tx_clock_polarity_i, .rx_clock_polarity_i,
    .tx_clock_dir_i, .rx_clock_dir_i, .generator_sync_to_input_i, .generator_clock_i,
    .generator_frame_sync_i, .generator_resync_o (resync), .tx_data_pin_o, .tx_data_pin_oe_o, .rx_data_pin_i,
    .tx_framesync_pin_i, .tx_framesync_pin_o, .tx_framesync_pin_oe_o, .rx_framesync_pin_i,
    .tx_clock_pin_i, .tx_clock_pin_o, .tx_clock_pin_oe_o, .rx_clock_pin_i, .rx_clock_pin_o,
    .rx_clock_pin_oe_o, .rx_word_o, .rx_word_valid_o
  );

  spt_codec_model u_codec (
    .start_i (start), .glitch_i (glitch), .clk_pol_i (tx_clock_polarity_i),
    .fs_pol_i (tx_framesync_polarity_i), .rx_pat_i (pat), .tx_data_i (tx_data_pin_o),
    .tx_oe_i (tx_data_pin_oe_o), .clk_pin_o (m_clk), .fs_pin_o (m_fs), .rx_pin_o (m_rx),
    .cap_o (cap), .busy_o (busy)
  );

  // ----------------------------------------
  // Clocks, monitor, tasks
  // ----------------------------------------
  initial
  begin
    core_clk_i = 1'b0;
    forever #25 core_clk_i = ~core_clk_i;
  end

  always @(posedge core_clk_i)
  begin
    gcnt <= gcnt + 2'h1;
    if (gen_run && (gcnt == 2'h3)) generator_clock_i <= #1 ~generator_clock_i;
    if (tx_irq_o === 1'b1) irq_cnt <= irq_cnt + 1;
    if (rx_word_valid_o === 1'b1) rx_last <= rx_word_o;
    if (resync === 1'b1) rs_cnt <= rs_cnt + 1;
    if ((tx_framesync_pin_oe_o === 1'b1) && (tx_framesync_pin_o !== tx_framesync_polarity_i)) act_cnt <= act_cnt + 1;
  end

  task automatic summarize();
    if ((error_cnt == 0) && (compares > 0)) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("mismatch at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk_i);
    #1;
  endtask

  task automatic put(input logic [15:0] w);
    int i;
    i = 0;
    while ((tx_ready_flag_o !== 1'b1) && (i < 100))
    begin
      cyc(1);
      i++;
    end
    tx_data_i       = w;
    tx_data_valid_i = 1'b1;
    cyc(1);
    tx_data_valid_i = 1'b0;
    cyc(4);
  endtask

  task automatic frame(input logic g);
    int i;
    glitch = g;
    start  = 1'b1;
    cyc(1);
    start = 1'b0;
    i     = 0;
    while ((busy === 1'b1) && (i < 600))
    begin
      cyc(1);
      i++;
    end
    cyc(8);
  endtask

  initial
  begin
    #600000;
    error_cnt++;
    summarize();
  end

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial
  begin
    {nrst_i, tx_enable_i, tx_data_valid_i, data_pin_delay_enable_i, abis_mode_i, abis_bit_enable_i,
     multichannel_active_i, tx_sync_error_clear_i, tx_unexpected_sync_ignore_i, tx_framesync_dir_i,
     tx_framesync_gen_select_i, tx_framesync_polarity_i, rx_framesync_polarity_i, tx_clock_polarity_i,
     rx_clock_polarity_i, tx_clock_dir_i, rx_clock_dir_i, generator_sync_to_input_i, generator_clock_i,
     generator_frame_sync_i, start, glitch, gen_run, tx_data_delay_i, rx_data_delay_i, tx_irq_mode_i,
     tx_compand_mode_i, gcnt, tx_data_i, rx_last, pat} = '0;
    cyc(2);
    cmp(32'({tx_ready_flag_o, tx_data_pin_oe_o, tx_irq_o}), 32'h4);
    cyc(14);
    nrst_i      = 1'b1;
    tx_enable_i = 1'b1;
    cyc(2);
    for (int n = 0; n < 4; n++)
    begin
      tx_data_delay_i         = ROWS[n].dly;
      rx_data_delay_i         = ROWS[n].dly;
      tx_clock_polarity_i     = ROWS[n].cpol;
      rx_clock_polarity_i     = ROWS[n].cpol;
      tx_framesync_polarity_i = ROWS[n].fpol;
      rx_framesync_polarity_i = ROWS[n].fpol;
      data_pin_delay_enable_i = ROWS[n].dpe;
      frame(1'b0);
      pat      = ROWS[n].pat;
      irq_base = irq_cnt;
      put(ROWS[n].word);
      cmp(32'(irq_cnt - irq_base), 32'h1);
      frame(1'b0);
      cmp(cap, 32'(ROWS[n].word) << (10 - ROWS[n].dly));
      cmp(32'(rx_last), 32'(ROWS[n].pat[19 - ROWS[n].dly -: 8]));
    end
    tx_clock_dir_i = 1'b1;
    rx_clock_dir_i = 1'b1;
    for (int v = 0; v < 4; v++)
    begin
      {tx_clock_polarity_i, generator_clock_i} = 2'(v);
      rx_clock_polarity_i = tx_clock_polarity_i;
      cyc(3);
      cmp(32'({tx_clock_pin_o, tx_clock_pin_oe_o, rx_clock_pin_o, rx_clock_pin_oe_o}),
          32'({v[0] ^ v[1], 1'b1, v[0] ^ v[1], 1'b1}));
    end
    {tx_clock_polarity_i, rx_clock_polarity_i, gen_run}   = 3'h7;
    {tx_framesync_dir_i, tx_framesync_gen_select_i} = 2'h3;
    for (int v = 0; v < 4; v++)
    begin
      {tx_framesync_polarity_i, generator_frame_sync_i} = 2'(v);
      cyc(20);
      cmp(32'({tx_framesync_pin_o, tx_framesync_pin_oe_o}), 32'({v[0] ^ v[1], 1'b1}));
    end
    tx_framesync_gen_select_i = 1'b0;
    generator_frame_sync_i    = 1'b0;
    cyc(20);
    act_base = act_cnt;
    put(16'h0F0F);
    cyc(200);
    cmp(32'(act_cnt - act_base), 32'h8);
    {tx_framesync_dir_i, tx_clock_dir_i, rx_clock_dir_i, gen_run} = 4'h0;
    cyc(4);
    frame(1'b0);
    tx_irq_mode_i = 2'h3;
    put(16'hC3A5);
    irq_base = irq_cnt;
    frame(1'b1);
    cmp(32'(tx_sync_error_o), 32'h1);
    cmp(cap & 32'h0001FFFF, 32'h0001874A);
    cmp(32'(irq_cnt - irq_base), 32'h1);
    tx_sync_error_clear_i = 1'b1;
    cyc(1);
    tx_sync_error_clear_i = 1'b0;
    cyc(2);
    cmp(32'(tx_sync_error_o), 32'h0);
    tx_unexpected_sync_ignore_i = 1'b1;
    put(16'h5AC3);
    irq_base = irq_cnt;
    frame(1'b1);
    cmp(32'({tx_sync_error_o, cap[30:0]}), 32'(16'h5AC3) << 9);
    cmp(32'(irq_cnt - irq_base), 32'h0);
    {tx_irq_mode_i, tx_compand_mode_i, multichannel_active_i, generator_sync_to_input_i} = 6'h17;
    put(16'h00C5);
    irq_base = irq_cnt;
    frame(1'b0);
    cmp(cap, 32'h01460000);
    cmp(32'(irq_cnt - irq_base), 32'h1);
    cmp(32'(rs_cnt), 32'h1);
    tx_irq_mode_i = 2'h2;
    tx_enable_i   = 1'b0;
    irq_base      = irq_cnt;
    frame(1'b0);
    cmp(32'(irq_cnt - irq_base), 32'h1);
    summarize();
  end
endmodule
`default_nettype wire
